// ===== hw/dsm_pkg.sv
// dsm_pkg: constants and types for the detector settings menu
// assumes a 25 MHz system clock; time figures are turned into cycles here
package dsm_pkg;
  // system clock rate
  localparam int CLK_HZ = 25_000_000;
  // times in milliseconds
  localparam int HOLD_MS = 6000;
  localparam int DEB_MS = 20;
  localparam int INHIBIT_MS = 60000;
  localparam int AUTOCAL_MS = 30000;
  // times in clock cycles
  localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
  localparam int INHIBIT_CYC = CLK_HZ / 1000 * INHIBIT_MS;
  localparam int AUTOCAL_CYC = CLK_HZ / 1000 * AUTOCAL_MS;
  // slave address range and reset
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [7:0] ADDR_RST = 8'h01;
  // bit rate index: 0=110 1=300 2=1200 3=2400 4=4800 5=9600 6=19200
  localparam logic [2:0] BAUD_MIN = 3'h0;
  localparam logic [2:0] BAUD_MAX = 3'h6;
  localparam logic [2:0] BAUD_RST = 3'h5;
  // fixed framing 8-N-1
  localparam logic [3:0] FRM_DATA_BITS = 4'h8;
  localparam logic [1:0] FRM_STOP_BITS = 2'h1;
  localparam logic FRM_PARITY_EN = 1'b0;
  // contrast range and reset
  localparam logic [6:0] CON_MIN = 7'h01;
  localparam logic [6:0] CON_MAX = 7'h40;
  localparam logic [6:0] CON_RST = 7'h1d;
  // loop trims in units of 10 uA
  localparam logic [11:0] ZERO_RST = 12'h190;
  localparam logic [11:0] ZERO_MIN = 12'h12c;
  localparam logic [11:0] ZERO_MAX = 12'h1f4;
  localparam logic [11:0] FULL_RST = 12'h7d0;
  localparam logic [11:0] FULL_MIN = 12'h76c;
  localparam logic [11:0] FULL_MAX = 12'h834;
  // register byte offsets
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_CFG = 12'h004;
  localparam logic [11:0] REG_TRIM = 12'h008;
  localparam logic [11:0] REG_CALTGT = 12'h00c;
  localparam logic [11:0] REG_CALCTL = 12'h010;
  localparam logic [11:0] REG_FLOAT = 12'h014;
  localparam logic [11:0] REG_FLOAT_TX = 12'h018;
  // register reset values
  localparam logic [15:0] CALTGT_RST = 16'h0000;
  localparam logic [31:0] FLOAT_RST = 32'h0000_0000;
  // menu screens
  typedef enum logic [3:0] {
    S_NORMAL, S_FAULT_FS, S_CAL_METHOD, S_ADDR, S_BAUD,
    S_LOOP_ENTRY, S_ZERO, S_FULL, S_CONTRAST
  } dsm_scr_t;
  // stored settings travelling together
  typedef struct packed {
    logic fault_fs;
    logic cal_auto;
    logic [7:0] addr;
    logic [2:0] baud;
    logic [6:0] contrast;
    logic [11:0] zero_trim;
    logic [11:0] full_trim;
  } dsm_cfg_t;
endpackage

// ===== hw/dsm_debounce.sv
// dsm_debounce: synchroniser and debouncer for one push button
// assumes an asynchronous, active-high button level from a pin
`timescale 1ns/1ns
`default_nettype none
module dsm_debounce #(
  parameter int DEB_CYC = 500000
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // raw pin
  input wire logic btn,
  // debounced level and edges
  output logic lvl_r,
  output logic press_r,
  output logic rel_r
);
  // refuse a settle time the counter cannot hold
  if (DEB_CYC < 1) begin : g_bad
    $error("debounce count must be at least one");
  end
  logic s1_r; // first sync stage, read only by s2_r
  logic s2_r; // second sync stage
  logic [31:0] cnt_r; // settle counter

  // two-stage synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= btn;
      s2_r <= s1_r;
    end
  end

  // level accepted only after it stays put for the settle time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 32'h0;
      lvl_r <= 1'b0;
      press_r <= 1'b0;
      rel_r <= 1'b0;
    end else begin
      press_r <= 1'b0;
      rel_r <= 1'b0;
      if (s2_r == lvl_r) begin
        cnt_r <= 32'h0;
      end else if (cnt_r >= 32'(DEB_CYC - 1)) begin
        // new stable level: one pulse per edge
        cnt_r <= 32'h0;
        lvl_r <= s2_r;
        press_r <= s2_r;
        rel_r <= ~s2_r;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/dsm_menu.sv
// dsm_menu: three-button settings menu of a gas detector with APB access
// assumes button and strap pins are asynchronous; rx address
// inputs come from link logic on the same clock
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - menu entry after six-second menu hold
// - selectable fault polarity, default deassert
// - light variant: fixed fail-safe, no screen
// - fault screen: inc/dec choose, menu advances
// - inc manual, dec auto; manual default
// - combustible and CO2 variants: auto only
// - auto cal: wait, then force target
// - slave address 1 to 247, default 1
// - answer only frames for own address
// - fixed 8-N-1 framing on both ends
// - floats sent least significant byte first
// - seven bit rates, default 9600
// - loop entry: inc trims, else contrast
// - zero trim adjust, menu stores, advance
// - full-scale screen drives loop full scale
// - contrast 1 to 64, default 29
// - menu release advances; last exits
// - alarms inhibited a minute after exit
module dsm_menu
  import dsm_pkg::*;
#(
  parameter int CLK_RATE = CLK_HZ,
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int DEB_CYCLES = DEB_CYC,
  parameter int INHIBIT_CYCLES = INHIBIT_CYC,
  parameter int AUTOCAL_CYCLES = AUTOCAL_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front-panel buttons and variant straps
  input wire logic btn_menu,
  input wire logic btn_inc,
  input wire logic btn_dec,
  input wire logic light_variant,
  input wire logic combustible_gas_variant,
  input wire logic co2_variant,
  // fault terminal
  input wire logic fault_in,
  output logic fault_out_r,
  // link side
  input wire logic rx_addr_vld,
  input wire logic [7:0] rx_addr,
  output logic addr_match_r,
  output logic bit_tick_r,
  output logic [31:0] float_tx_r,
  // calibration
  output logic cal_force_r,
  output logic [15:0] cal_value_r,
  // menu state and settings
  output dsm_scr_t scr_r,
  output dsm_cfg_t cfg_r,
  output logic loop_full_r,
  output logic alarm_inhibit_r
);
  // refuse counts the logic cannot serve
  if (HOLD_CYCLES < 1 || INHIBIT_CYCLES < 1 || AUTOCAL_CYCLES < 1) begin : g_bad
    $error("timing counts must be at least one");
  end
  if (CLK_RATE < 2 * 19200) begin : g_slow
    $error("clock too slow for the highest bit rate");
  end

  logic m_lvl, m_press, m_rel; // menu button
  logic i_lvl, i_press, i_rel; // increment button
  logic d_lvl, d_press, d_rel; // decrement button
  logic [2:0] st1_r, st2_r; // strap and fault syncs
  logic f1_r, f2_r;
  logic [31:0] hold_cnt_r; // menu hold timer
  logic swallow_r; // ignore release that entered the menu
  logic [11:0] zero_edit_r, full_edit_r; // trims being edited
  logic [31:0] inh_cnt_r; // post-menu inhibit timer
  logic [31:0] cal_cnt_r; // auto-cal wait timer
  logic cal_busy_r;
  logic [15:0] caltgt_r; // auto-cal target
  logic cal_start; // software start pulse
  logic [31:0] float_r; // value to send
  logic [31:0] baud_cnt_r, baud_div;
  logic wr_en, rd_en; // apb phases
  logic light_s, comb_s, auto_only;
  dsm_scr_t adv;

  assign light_s = st2_r[0];
  assign comb_s = st2_r[1];
  assign auto_only = st2_r[1] | st2_r[2];

  dsm_debounce #(.DEB_CYC(DEB_CYCLES)) u_deb_m (.clk(clk), .arst_n(arst_n),
    .btn(btn_menu), .lvl_r(m_lvl), .press_r(m_press), .rel_r(m_rel));
  dsm_debounce #(.DEB_CYC(DEB_CYCLES)) u_deb_i (.clk(clk), .arst_n(arst_n),
    .btn(btn_inc), .lvl_r(i_lvl), .press_r(i_press), .rel_r(i_rel));
  dsm_debounce #(.DEB_CYC(DEB_CYCLES)) u_deb_d (.clk(clk), .arst_n(arst_n),
    .btn(btn_dec), .lvl_r(d_lvl), .press_r(d_press), .rel_r(d_rel));

  // straps and fault level pass two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st1_r <= 3'h0;
      st2_r <= 3'h0;
      f1_r <= 1'b0;
      f2_r <= 1'b0;
    end else begin
      st1_r <= {co2_variant, combustible_gas_variant, light_variant};
      st2_r <= st1_r;
      f1_r <= fault_in;
      f2_r <= f1_r;
    end
  end

  // screen after the current one, skipping screens a variant hides
  always_comb begin
    case (scr_r)
      S_NORMAL: adv = light_s ? (auto_only ? S_ADDR : S_CAL_METHOD) : S_FAULT_FS;
      S_FAULT_FS: adv = auto_only ? S_ADDR : S_CAL_METHOD;
      S_CAL_METHOD: adv = S_ADDR;
      S_ADDR: adv = S_BAUD;
      S_BAUD: adv = S_LOOP_ENTRY;
      S_LOOP_ENTRY: adv = S_CONTRAST;
      S_ZERO: adv = S_FULL;
      S_FULL: adv = S_CONTRAST;
      S_CONTRAST: adv = S_NORMAL;
      default: adv = S_NORMAL;
    endcase
  end

  // menu hold timer in normal operation
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_r <= 32'h0;
    end else if (scr_r != S_NORMAL || !m_lvl) begin
      hold_cnt_r <= 32'h0;
    end else if (hold_cnt_r < 32'(HOLD_CYCLES)) begin
      hold_cnt_r <= hold_cnt_r + 32'h1;
    end
  end

  // screen sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scr_r <= S_NORMAL;
      swallow_r <= 1'b0;
    end else begin
      case (scr_r)
        S_NORMAL: begin
          if (m_lvl && hold_cnt_r == 32'(HOLD_CYCLES - 1)) begin
            scr_r <= adv;
            swallow_r <= 1'b1;
          end
        end
        S_LOOP_ENTRY: begin
          // inc opens trims, dec or menu skips
          if (i_rel) begin
            scr_r <= S_ZERO;
          end else if (d_rel || m_rel) begin
            scr_r <= S_CONTRAST;
          end
        end
        default: begin
          if (m_rel && swallow_r) begin
            swallow_r <= 1'b0;
          end else if (m_rel) begin
            scr_r <= adv;
          end
        end
      endcase
    end
  end

  // fault polarity setting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r.fault_fs <= 1'b0;
    end else if (scr_r == S_FAULT_FS) begin
      if (i_rel) begin
        cfg_r.fault_fs <= 1'b1;
      end else if (d_rel) begin
        cfg_r.fault_fs <= 1'b0;
      end
    end
  end

  // fault terminal drive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_out_r <= 1'b1;
    end else if (light_s) begin
      fault_out_r <= f2_r;
    end else begin
      fault_out_r <= cfg_r.fault_fs ? f2_r : ~f2_r;
    end
  end

  // calibration method
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r.cal_auto <= 1'b0;
    end else if (scr_r == S_CAL_METHOD) begin
      if (i_rel) begin
        cfg_r.cal_auto <= 1'b0;
      end else if (d_rel) begin
        cfg_r.cal_auto <= 1'b1;
      end
    end
  end

  // slave address
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r.addr <= ADDR_RST;
    end else if (scr_r == S_ADDR) begin
      if (i_rel && cfg_r.addr < ADDR_MAX) begin
        cfg_r.addr <= cfg_r.addr + 8'h01;
      end else if (d_rel && cfg_r.addr > ADDR_MIN) begin
        cfg_r.addr <= cfg_r.addr - 8'h01;
      end
    end
  end

  // bit rate selection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r.baud <= BAUD_RST;
    end else if (scr_r == S_BAUD) begin
      if (i_rel && cfg_r.baud < BAUD_MAX) begin
        cfg_r.baud <= cfg_r.baud + 3'h1;
      end else if (d_rel && cfg_r.baud > BAUD_MIN) begin
        cfg_r.baud <= cfg_r.baud - 3'h1;
      end
    end
  end

  // loop trims: edit copies, store on menu
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_edit_r <= ZERO_RST;
      full_edit_r <= FULL_RST;
      cfg_r.zero_trim <= ZERO_RST;
      cfg_r.full_trim <= FULL_RST;
    end else begin
      case (scr_r)
        S_LOOP_ENTRY: begin
          // start from the stored values
          zero_edit_r <= cfg_r.zero_trim;
          full_edit_r <= cfg_r.full_trim;
        end
        S_ZERO: begin
          if (i_rel && zero_edit_r < ZERO_MAX) begin
            zero_edit_r <= zero_edit_r + 12'h001;
          end else if (d_rel && zero_edit_r > ZERO_MIN) begin
            zero_edit_r <= zero_edit_r - 12'h001;
          end else if (m_rel) begin
            cfg_r.zero_trim <= zero_edit_r;
          end
        end
        S_FULL: begin
          if (i_rel && full_edit_r < FULL_MAX) begin
            full_edit_r <= full_edit_r + 12'h001;
          end else if (d_rel && full_edit_r > FULL_MIN) begin
            full_edit_r <= full_edit_r - 12'h001;
          end else if (m_rel) begin
            cfg_r.full_trim <= full_edit_r;
          end
        end
        default: begin
          zero_edit_r <= zero_edit_r;
        end
      endcase
    end
  end

  // contrast
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r.contrast <= CON_RST;
    end else if (scr_r == S_CONTRAST) begin
      if (i_rel && cfg_r.contrast < CON_MAX) begin
        cfg_r.contrast <= cfg_r.contrast + 7'h01;
      end else if (d_rel && cfg_r.contrast > CON_MIN) begin
        cfg_r.contrast <= cfg_r.contrast - 7'h01;
      end
    end
  end

  // loop forced to full scale and alarm inhibit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loop_full_r <= 1'b0;
      inh_cnt_r <= 32'h0;
      alarm_inhibit_r <= 1'b0;
    end else begin
      loop_full_r <= (scr_r == S_FULL);
      // inhibit in menu and a minute after
      if (scr_r != S_NORMAL) begin
        inh_cnt_r <= 32'(INHIBIT_CYCLES);
        alarm_inhibit_r <= 1'b1;
      end else if (inh_cnt_r != 32'h0) begin
        inh_cnt_r <= inh_cnt_r - 32'h1;
        alarm_inhibit_r <= (inh_cnt_r != 32'h1);
      end else begin
        alarm_inhibit_r <= 1'b0;
      end
    end
  end

  // timed automatic calibration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_busy_r <= 1'b0;
      cal_cnt_r <= 32'h0;
      cal_force_r <= 1'b0;
      cal_value_r <= CALTGT_RST;
    end else begin
      cal_force_r <= 1'b0;
      if (cal_start && !cal_busy_r && (cfg_r.cal_auto || auto_only)) begin
        cal_busy_r <= 1'b1;
        cal_cnt_r <= 32'(AUTOCAL_CYCLES - 1);
      end else if (cal_busy_r && cal_cnt_r != 32'h0) begin
        cal_cnt_r <= cal_cnt_r - 32'h1;
      end else if (cal_busy_r) begin
        cal_busy_r <= 1'b0;
        cal_force_r <= 1'b1;
        cal_value_r <= caltgt_r;
      end
    end
  end

  // link helpers: address filter, byte order, bit clock enable
  always_comb begin
    case (cfg_r.baud)
      3'h0: baud_div = 32'(CLK_RATE / 110);
      3'h1: baud_div = 32'(CLK_RATE / 300);
      3'h2: baud_div = 32'(CLK_RATE / 1200);
      3'h3: baud_div = 32'(CLK_RATE / 2400);
      3'h4: baud_div = 32'(CLK_RATE / 4800);
      3'h5: baud_div = 32'(CLK_RATE / 9600);
      default: baud_div = 32'(CLK_RATE / 19200);
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_match_r <= 1'b0;
      float_tx_r <= FLOAT_RST;
      baud_cnt_r <= 32'h0;
      bit_tick_r <= 1'b0;
    end else begin
      addr_match_r <= rx_addr_vld && (rx_addr == cfg_r.addr);
      float_tx_r <= {float_r[7:0], float_r[15:8], float_r[23:16], float_r[31:24]};
      // one tick per bit of 8-N-1 frame
      if (baud_cnt_r >= baud_div - 32'h1) begin
        baud_cnt_r <= 32'h0;
        bit_tick_r <= 1'b1;
      end else begin
        baud_cnt_r <= baud_cnt_r + 32'h1;
        bit_tick_r <= 1'b0;
      end
    end
  end

  // apb: one wait state; reads sampled while pready is low, writes taken when pready is high
  assign rd_en = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite;
  assign cal_start = wr_en && paddr == REG_CALCTL && pwdata[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_en;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (rd_en) begin
        case (paddr)
          REG_STATUS: prdata <= {18'h0, FRM_PARITY_EN, FRM_STOP_BITS, FRM_DATA_BITS,
                                 cal_busy_r, alarm_inhibit_r, loop_full_r, 4'(scr_r)};
          REG_CFG: prdata <= {10'h0, cfg_r.contrast, cfg_r.baud, cfg_r.addr,
                              cfg_r.cal_auto, cfg_r.fault_fs, light_s, comb_s};
          REG_TRIM: prdata <= {4'h0, cfg_r.full_trim, 4'h0, cfg_r.zero_trim};
          REG_CALTGT: prdata <= {16'h0, caltgt_r};
          REG_CALCTL: prdata <= {31'h0, cal_busy_r};
          REG_FLOAT: prdata <= float_r;
          REG_FLOAT_TX: prdata <= float_tx_r;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // software-written registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      caltgt_r <= CALTGT_RST;
      float_r <= FLOAT_RST;
    end else if (wr_en && paddr == REG_CALTGT) begin
      caltgt_r <= pwdata[15:0];
    end else if (wr_en && paddr == REG_FLOAT) begin
      float_r <= pwdata;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/dsm_menu_chk.sv
// dsm_menu_chk: concurrent checks on the settings menu ports
// assumes it is bound into dsm_menu and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module dsm_menu_chk
  import dsm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link side
  input wire logic rx_addr_vld,
  input wire logic [7:0] rx_addr,
  input wire logic addr_match_r,
  // menu state and outputs
  input wire logic loop_full_r,
  input wire logic alarm_inhibit_r,
  input wire logic cal_force_r,
  input wire dsm_scr_t scr_r,
  input wire dsm_cfg_t cfg_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // match pulse one cycle after a field naming us
  match_own_a: assert property (
    1'b1 |=> addr_match_r == $past(rx_addr_vld && rx_addr == cfg_r.addr))
    else $error("address match pulse wrong");
  // address stays in its legal span
  addr_range_a: assert property (
    cfg_r.addr >= ADDR_MIN && cfg_r.addr <= ADDR_MAX)
    else $error("slave address out of range");
  // rate index stays within the table
  rate_range_a: assert property (
    cfg_r.baud <= BAUD_MAX)
    else $error("bit rate index out of range");
  // contrast stays in its legal span
  con_range_a: assert property (
    cfg_r.contrast >= CON_MIN && cfg_r.contrast <= CON_MAX)
    else $error("contrast out of range");
  // contrast moves by one step only
  con_step_a: assert property (
    cfg_r.contrast != $past(cfg_r.contrast) |->
    (7'(cfg_r.contrast - $past(cfg_r.contrast)) inside {7'h01, 7'h7f}))
    else $error("contrast jumped by more than one");
  // address moves by one step only
  addr_step_a: assert property (
    cfg_r.addr != $past(cfg_r.addr) |->
    (8'(cfg_r.addr - $past(cfg_r.addr)) inside {8'h01, 8'hff}))
    else $error("address jumped by more than one");
  // loop driven full scale one cycle behind each cycle on that screen
  full_drive_a: assert property (
    1'b1 |=> loop_full_r == $past(scr_r == S_FULL))
    else $error("loop full-scale drive wrong");
  // alarms held off while in the menu
  inh_menu_a: assert property (
    scr_r != S_NORMAL && $past(scr_r != S_NORMAL) |-> alarm_inhibit_r)
    else $error("alarms not inhibited in menu");
  // alarms still held off just after leaving
  inh_hold_a: assert property (
    scr_r == S_NORMAL && $past(scr_r != S_NORMAL) |-> alarm_inhibit_r [*8])
    else $error("inhibit dropped right after exit");
  // main scenarios reached
  cover property (cal_force_r);
  cover property (addr_match_r);
  cover property (scr_r == S_FULL);
  cover property (scr_r == S_NORMAL && $past(scr_r) == S_CONTRAST);
endmodule
bind dsm_menu dsm_menu_chk dsm_menu_chk_inst (.clk(clk), .arst_n(arst_n), .rx_addr_vld(rx_addr_vld),
  .rx_addr(rx_addr), .addr_match_r(addr_match_r), .loop_full_r(loop_full_r),
  .alarm_inhibit_r(alarm_inhibit_r), .cal_force_r(cal_force_r), .scr_r(scr_r), .cfg_r(cfg_r));
`default_nettype wire

// ===== testbench/dsm_mb_master.sv
// dsm_mb_master: behavioural serial bus master polling the detector
// assumes link logic hands over bit ticks and received address fields
`timescale 1ns/1ns
`default_nettype none
module dsm_mb_master (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // from the detector
  input wire logic bit_tick,
  input wire logic addr_match,
  // to the detector
  output logic rx_addr_vld,
  output logic [7:0] rx_addr,
  // measured bit period in cycles
  output logic [15:0] tick_gap
);
  // cycles since the last bit tick
  logic [15:0] cnt_r;
  initial begin
    rx_addr_vld = 1'b0;
    rx_addr = 8'h00;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 16'h0001;
      tick_gap <= 16'h0000;
    end else if (bit_tick) begin
      tick_gap <= cnt_r;
      cnt_r <= 16'h0001;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  task automatic poll(input logic [7:0] a, output logic hit);
    @(posedge clk);
    rx_addr_vld <= 1'b1;
    rx_addr <= a;
    @(posedge clk);
    rx_addr_vld <= 1'b0;
    // released field shows the inverse, never the old value
    rx_addr <= ~a;
    #1 hit = addr_match;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// tb: self-checking bench for the detector settings menu
// assumes shortened counts passed as parameters and a 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb
  import dsm_pkg::*;
;
  localparam int HOLD = 50;
  localparam int INH = 100;
  localparam int ACAL = 20;
  localparam int RATE = 384000;
  localparam int BM = 0;
  localparam int BI = 1;
  localparam int BD = 2;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err, hit;
  logic light, fault_in, fault_out, vld, match, tick, cal_force, loop_full, inhibit;
  logic [2:0] btn;
  logic [7:0] rx_addr;
  logic [11:0] paddr;
  logic [15:0] cal_value, gap, c;
  logic [31:0] pwdata, prdata, float_tx, rd, v;
  dsm_scr_t scr;
  dsm_cfg_t cfg, e;
  int fail_count, num_checks, seed, k, t, since;
  int rates [7] = '{110, 300, 1200, 2400, 4800, 9600, 19200};
  dsm_menu #(.CLK_RATE(RATE), .HOLD_CYCLES(HOLD), .DEB_CYCLES(4), .INHIBIT_CYCLES(INH),
    .AUTOCAL_CYCLES(ACAL)) dsm_menu_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .btn_menu(btn[0]), .btn_inc(btn[1]), .btn_dec(btn[2]),
    .light_variant(light), .combustible_gas_variant(light), .co2_variant(1'b0),
    .fault_in(fault_in), .fault_out_r(fault_out), .rx_addr_vld(vld), .rx_addr(rx_addr),
    .addr_match_r(match), .bit_tick_r(tick), .float_tx_r(float_tx), .cal_force_r(cal_force),
    .cal_value_r(cal_value), .scr_r(scr), .cfg_r(cfg), .loop_full_r(loop_full),
    .alarm_inhibit_r(inhibit));
  dsm_mb_master dsm_mb_master_inst (.clk(clk), .arst_n(arst_n), .bit_tick(tick),
    .addr_match(match), .rx_addr_vld(vld), .rx_addr(rx_addr), .tick_gap(gap));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cycles spent in normal operation
  always @(posedge clk) begin
    since <= (scr !== S_NORMAL) ? 0 : since + 1;
  end
  // saturating step of a setting
  function automatic int sat(input int x, input int lo, input int hi, input int d);
    if (x + d < lo) return lo;
    if (x + d > hi) return hi;
    return x + d;
  endfunction
  // order of bytes on the line
  function automatic logic [31:0] swap(input logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
    chk("pready", 64'h1, 64'(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // press and release one button
  task automatic press(input int b, input int len);
    btn[b] <= 1'b1;
    repeat (len) @(posedge clk);
    btn[b] <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  // short press, then screen and settings compared
  task automatic step(input int b, input dsm_scr_t s);
    press(b, 10);
    chk("scr", 64'(s), 64'(scr));
    chk("cfg", 64'(e), 64'(cfg));
  endtask
  // timeout guard
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    seed = 32'h2f7d;
    {arst_n, psel, penable, pwrite, paddr, pwdata, btn, light, fault_in} = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    e = {1'b0, 1'b0, ADDR_RST, BAUD_RST, CON_RST, ZERO_RST, FULL_RST};
    chk("cfg", 64'(e), 64'(cfg));
    fault_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk("fault out", 64'h0, 64'(fault_out));
    step(BM, S_NORMAL);
    press(BM, HOLD + 20);
    chk("scr", 64'(S_FAULT_FS), 64'(scr));
    e.fault_fs = 1'b1;
    step(BI, S_FAULT_FS);
    chk("fault out", 64'h1, 64'(fault_out));
    e.fault_fs = 1'b0;
    step(BD, S_FAULT_FS);
    step(BM, S_CAL_METHOD);
    e.cal_auto = 1'b1;
    step(BD, S_CAL_METHOD);
    e.cal_auto = 1'b0;
    step(BI, S_CAL_METHOD);
    e.cal_auto = 1'b0;
    step(BI, S_CAL_METHOD);
    step(BM, S_ADDR);
    step(BD, S_ADDR);
    for (int i = 0; i < 247; i++) begin
      e.addr = 8'(sat(e.addr, 1, 247, 1));
      step(BI, S_ADDR);
    end
    dsm_mb_master_inst.poll(e.addr, hit);
    chk("own addr", 64'h1, 64'(hit));
    dsm_mb_master_inst.poll(e.addr + 8'(1 + $unsigned($random(seed)) % 200), hit);
    chk("other addr", 64'h0, 64'(hit));
    step(BM, S_BAUD);
    repeat (6) begin
      e.baud = 3'(sat(e.baud, 0, 6, -1));
      step(BD, S_BAUD);
    end
    for (int i = 0; i < 7; i++) begin
      for (t = 0, k = 0; t < 3 && k < 12000; k++) begin
        @(posedge clk);
        t += (tick === 1'b1);
      end
      @(posedge clk);
      chk("ticks", 64'h3, 64'(t));
      chk("bit period", 64'(RATE / rates[i]), 64'(gap));
      e.baud = 3'(sat(e.baud, 0, 6, 1));
      step(BI, S_BAUD);
    end
    e.baud = BAUD_RST;
    step(BD, S_BAUD);
    step(BM, S_LOOP_ENTRY);
    step(BD, S_CONTRAST);
    e.contrast = e.contrast + 7'h01;
    step(BI, S_CONTRAST);
    step(BM, S_NORMAL);
    for (k = 0; k < INH + 50 && inhibit === 1'b1; k++) @(posedge clk);
    chk("inhibit len", 64'h1, 64'(since >= INH - 2 && since <= INH + 4));
    light <= 1'b1;
    repeat (4) @(posedge clk);
    chk("fault out", 64'h1, 64'(fault_out));
    press(BM, HOLD + 20);
    chk("scr", 64'(S_ADDR), 64'(scr));
    step(BI, S_ADDR);
    step(BM, S_BAUD);
    step(BM, S_LOOP_ENTRY);
    step(BI, S_ZERO);
    step(BI, S_ZERO);
    e.zero_trim = ZERO_RST + 12'h001;
    step(BM, S_FULL);
    chk("loop full", 64'h1, 64'(loop_full));
    step(BD, S_FULL);
    e.full_trim = FULL_RST - 12'h001;
    step(BM, S_CONTRAST);
    repeat (36) begin
      e.contrast = 7'(sat(e.contrast, 1, 64, 1));
      step(BI, S_CONTRAST);
    end
    step(BM, S_NORMAL);
    v = $random(seed);
    apb(1'b1, REG_FLOAT, v);
    apb(1'b0, REG_FLOAT_TX, 32'h0);
    chk("float read", 64'(swap(v)), 64'(rd));
    chk("float pin", 64'(swap(v)), 64'(float_tx));
    apb(1'b0, REG_STATUS, 32'h0);
    chk("framing", 64'h18, 64'(rd[13:7]));
    apb(1'b0, 12'h0fc, 32'h0);
    chk("slverr", 64'h1, 64'(err));
    c = 16'($random(seed));
    apb(1'b1, REG_CALTGT, {16'h0, c});
    apb(1'b1, REG_CALCTL, 32'h1);
    for (k = 0; k < ACAL + 40 && cal_force !== 1'b1; k++) @(posedge clk);
    chk("cal wait", 64'h1, 64'(k >= ACAL - 2 && k <= ACAL + 4));
    chk("cal value", 64'(c), 64'(cal_value));
    wrap_up();
  end
endmodule
`default_nettype wire
